// >>> rtl/uoc_top.v
/*
 Endpoint control top: APB register port, the OUT endpoint 0 control
 word, the IN endpoint 0 size code, and IN/OUT endpoints 1 to 3.
 Assumes the USB protocol engine runs on pclk and pulses events for
 one cycle; it reads the handshake and configuration outputs here.
*/
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "uoc_defs.vh"

module uoc_top (
	input  wire        pclk,
	input  wire        presetn,
	// APB register port
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Engine events
	input  wire        usb_bus_reset,
	input  wire        out0_setup_token,
	input  wire [3:0]  out_setup_pkt,
	input  wire [3:0]  out_xfer_done,
	input  wire [3:0]  out_setup_done,
	input  wire [3:1]  out_stop_ack,
	input  wire [3:1]  out_toggle_adv,
	input  wire [3:1]  in_setup_pkt,
	input  wire [3:1]  in_xfer_done,
	input  wire [3:1]  in_setup_done,
	input  wire [3:1]  in_stop_ack,
	input  wire [3:1]  in_toggle_adv,
	// OUT endpoint state toward the engine
	output wire [3:0]  out_run,
	output wire [3:1]  out_stop_req,
	output wire [3:0]  out_stall_hs,
	output wire [3:0]  out_nak_hs,
	output wire [3:0]  out_setup_ack,
	output wire [3:0]  out_unchecked,
	output wire [5:0]  out_transfer_type,
	output wire [3:1]  out_data_toggle,
	output wire [3:0]  out_ep_active,
	output wire [32:0] out_max_bytes,
	output wire [1:0]  out0_max_code,
	output wire [3:0]  out_xfer_int,
	output wire [3:0]  out_setup_int,
	output wire [3:1]  out_dis_int,
	// IN endpoint state toward the engine
	output wire [1:0]  in0_max_code,
	output wire [3:1]  in_run,
	output wire [3:1]  in_stop_req,
	output wire [3:1]  in_stall_hs,
	output wire [3:1]  in_hold,
	output wire [3:1]  in_zero_len,
	output wire [5:0]  in_transfer_type,
	output wire [3:1]  in_data_toggle,
	output wire [3:1]  in_ep_active,
	output wire [32:0] in_max_bytes,
	output wire [3:1]  in_xfer_int,
	output wire [3:1]  in_setup_int,
	output wire [3:1]  in_dis_int
);

	// Bus front end
	wire        hit;
	wire [2:0]  slot;
	wire [7:0]  wr_en;
	wire        rd_load;

	// Endpoint 0 state
	reg         ep0_run_r;
	reg         ep0_stall_r;
	reg         ep0_unchk_r;
	reg         ep0_nak_r;
	reg  [1:0]  in0_mps_r;
	reg         ep0_xfer_int_r;
	reg         ep0_setup_int_r;
	wire        ep0_done;
	wire [31:0] ep0_rdata;
	wire [31:0] in0_rdata;

	// Endpoints 1 to 3, one 32-bit word each
	wire [95:0] out_rd_w;
	wire [95:0] in_rd_w;
	wire [3:1]  out_nak_n;
	wire [3:1]  in_nak_n;
	wire [31:0] rd_nxt;

	uoc_apb_slv u_apb (
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pready  (pready),
		.pslverr (pslverr),
		.hit     (hit),
		.slot    (slot),
		.wr_en   (wr_en),
		.rd_load (rd_load)
	);

	// Endpoint 0 leaves run on any completion event; there is no stop
	assign ep0_done = out_xfer_done[0] | out_setup_done[0];

	// Endpoint 0 OUT control word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep0_run_r       <= 1'b0;
			ep0_stall_r     <= 1'b0;
			ep0_unchk_r     <= 1'b0;
			ep0_nak_r       <= 1'b0;
			ep0_xfer_int_r  <= 1'b0;
			ep0_setup_int_r <= 1'b0;
		end else begin
			// Run is write-one-to-set; completion clears it first
			if (ep0_done)
				ep0_run_r <= 1'b0;
			else if (wr_en[0] && pwdata[`UOC_B_RUN])
				ep0_run_r <= 1'b1;
			// A write of one sets STALL; a SETUP token takes it away
			if (wr_en[0] && pwdata[`UOC_B_STALL])
				ep0_stall_r <= 1'b1;
			else if (out0_setup_token)
				ep0_stall_r <= 1'b0;
			if (wr_en[0])
				ep0_unchk_r <= pwdata[`UOC_B_UNCHK];
			// Hardware set beats a clear strobe on the same edge
			if (out_xfer_done[0] || out_setup_pkt[0] ||
				(wr_en[0] && pwdata[`UOC_B_NAKSET]))
				ep0_nak_r <= 1'b1;
			else if (wr_en[0] && pwdata[`UOC_B_NAKCLR])
				ep0_nak_r <= 1'b0;
			ep0_xfer_int_r  <= out_xfer_done[0];
			ep0_setup_int_r <= out_setup_done[0];
		end
	end

	// IN endpoint 0 size code, mirrored into the OUT 0 word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			in0_mps_r <= `UOC_RST_MPS0;
		else if (wr_en[4])
			in0_mps_r <= pwdata[`UOC_B_MPS0_HI:0];
	end

	// Stop bit, type and strobes read zero; active is tied to one
	assign ep0_rdata = {ep0_run_r, 1'b0, 4'h0, 4'h0,
		ep0_stall_r, ep0_unchk_r, `UOC_TYPE_CTRL,
		ep0_nak_r, 1'b0, `UOC_RST_EP0_ACT,
		13'h0000, in0_mps_r};
	assign in0_rdata = {30'h0000_0000, in0_mps_r};

	// Endpoint 0 outputs toward the engine
	assign out_run[0]       = ep0_run_r;
	assign out_stall_hs[0]  = ep0_stall_r;
	// NAK only counts when STALL is clear
	assign out_nak_hs[0]    = ep0_nak_r & ~ep0_stall_r;
	assign out_unchecked[0] = ep0_unchk_r;
	assign out_ep_active[0] = `UOC_RST_EP0_ACT;
	assign out0_max_code    = in0_mps_r;
	assign in0_max_code     = in0_mps_r;
	assign out_xfer_int[0]  = ep0_xfer_int_r;
	assign out_setup_int[0] = ep0_setup_int_r;

	// SETUP data is acknowledged whatever NAK or STALL shows
	assign out_setup_ack    = out_setup_pkt;

	// Endpoints 1 to 3, both directions
	genvar i;
	generate
		for (i = 1; i < 4; i = i + 1) begin : g_ep
			uoc_ep_ctl u_out (
				.pclk          (pclk),
				.presetn       (presetn),
				.wr_en         (wr_en[i]),
				.wdata         (pwdata),
				.usb_bus_reset (usb_bus_reset),
				.setup_pkt     (out_setup_pkt[i]),
				.xfer_done     (out_xfer_done[i]),
				.setup_done    (out_setup_done[i]),
				.stop_ack      (out_stop_ack[i]),
				.toggle_adv    (out_toggle_adv[i]),
				.rdata         (out_rd_w[32*i-1 -: 32]),
				.run_r         (out_run[i]),
				.stop_r        (out_stop_req[i]),
				.stall_hs      (out_stall_hs[i]),
				.nak_hs        (out_nak_n[i]),
				.zero_len      (),
				.unchk_r       (out_unchecked[i]),
				.type_r        (out_transfer_type[2*i-1 -: 2]),
				.toggle_r      (out_data_toggle[i]),
				.active_r      (out_ep_active[i]),
				.mps_r         (out_max_bytes[11*i-1 -: 11]),
				.xfer_int_r    (out_xfer_int[i]),
				.setup_int_r   (out_setup_int[i]),
				.dis_int_r     (out_dis_int[i])
			);

			uoc_ep_ctl u_in (
				.pclk          (pclk),
				.presetn       (presetn),
				.wr_en         (wr_en[i+4]),
				.wdata         (pwdata),
				.usb_bus_reset (usb_bus_reset),
				.setup_pkt     (in_setup_pkt[i]),
				.xfer_done     (in_xfer_done[i]),
				.setup_done    (in_setup_done[i]),
				.stop_ack      (in_stop_ack[i]),
				.toggle_adv    (in_toggle_adv[i]),
				.rdata         (in_rd_w[32*i-1 -: 32]),
				.run_r         (in_run[i]),
				.stop_r        (in_stop_req[i]),
				.stall_hs      (in_stall_hs[i]),
				.nak_hs        (in_nak_n[i]),
				.zero_len      (in_zero_len[i]),
				.unchk_r       (),
				.type_r        (in_transfer_type[2*i-1 -: 2]),
				.toggle_r      (in_data_toggle[i]),
				.active_r      (in_ep_active[i]),
				.mps_r         (in_max_bytes[11*i-1 -: 11]),
				.xfer_int_r    (in_xfer_int[i]),
				.setup_int_r   (in_setup_int[i]),
				.dis_int_r     (in_dis_int[i])
			);

			// OUT refuses all data under NAK, sync or not
			assign out_nak_hs[i] = out_nak_n[i];
			// Non-sync IN holds its data; sync IN goes zero length
			assign in_hold[i] = in_nak_n[i] & ~in_zero_len[i];
		end
	endgenerate

	// Read word for the addressed slot, zero when unmapped
	assign rd_nxt = !hit        ? `UOC_RST_WORD :
		(slot == 3'd0) ? ep0_rdata       :
		(slot == 3'd1) ? out_rd_w[31:0]  :
		(slot == 3'd2) ? out_rd_w[63:32] :
		(slot == 3'd3) ? out_rd_w[95:64] :
		(slot == 3'd4) ? in0_rdata       :
		(slot == 3'd5) ? in_rd_w[31:0]   :
		(slot == 3'd6) ? in_rd_w[63:32]  :
		in_rd_w[95:64];

	// Read data captured in setup, so it is steady through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= `UOC_RST_WORD;
		else if (rd_load)
			prdata <= rd_nxt;
	end

endmodule
`default_nettype wire

// >>> rtl/uoc_defs.vh
/*
 Constants for the USB device endpoint control block: register byte
 addresses, control word field positions and reset values.
 Assumes a 32-bit APB register port with a 12-bit byte address.
*/
// Summary of operation
// - Interrupt/bulk IN endpoints hold next data toggle in read-only bit; software sets it.
// - Synchronous IN endpoints use that bit as frame parity, chosen by set strobes.
// - USB bus reset clears ep_active of every endpoint except endpoint 0.
// - OUT endpoint 0 run request cleared by hardware before its completion events.
// - OUT endpoint 0 stop request bit is read-only; it cannot be disabled.
// - OUT endpoint 0 NAK set by strobe, transfer complete or SETUP packet.
// - The clear-NAK strobe clears the endpoint NAK state.
// - OUT endpoint 0 STALL cleared by SETUP token; STALL beats NAK.
// - Snoop mode passes OUT packets on without correctness checking.
// - OUT endpoint 0 transfer type is read-only zero, control.
// - NAK state refuses OUT data; SETUP packets are always acknowledged.
// - OUT endpoint 0 ep_active is read-only and resets to one.
// - OUT endpoint 0 max packet code mirrors IN endpoint 0 setting.
// - OUT endpoints 1 to 3 run request cleared before completion events.
// - Stop request allowed only while running; cleared before disabled event.
// - Force-one and force-zero strobes set toggle or odd/even frame parity.
// - OUT endpoints 1 to 3 NAK set by strobe, transfer complete or SETUP.
// - Non-control STALL stalls all tokens and beats NAK except on sync endpoints; cleared only by software.
// - Endpoint 1 to 3 transfer type: 00 control, 01 sync, 10 bulk, 11 interrupt.
// - NAK on IN: non-sync stops sending, sync sends zero-length packet.
`ifndef UOC_DEFS_VH
`define UOC_DEFS_VH

// Register byte addresses
`define UOC_A_OUT0      12'h000
`define UOC_A_OUT1      12'h004
`define UOC_A_OUT2      12'h008
`define UOC_A_OUT3      12'h00C
`define UOC_A_IN0MPS    12'h010
`define UOC_A_IN1       12'h014
`define UOC_A_IN2       12'h018
`define UOC_A_IN3       12'h01C
`define UOC_A_LAST      12'h01C

// Control word field positions
`define UOC_B_RUN       31
`define UOC_B_STOP      30
`define UOC_B_FORCE1    29
`define UOC_B_FORCE0    28
`define UOC_B_NAKSET    27
`define UOC_B_NAKCLR    26
`define UOC_B_STALL     21
`define UOC_B_UNCHK     20
`define UOC_B_TYPE_HI   19
`define UOC_B_TYPE_LO   18
`define UOC_B_NAKST     17
`define UOC_B_TOGGLE    16
`define UOC_B_ACTIVE    15
`define UOC_B_MPS_HI    10
`define UOC_B_MPS0_HI   1

// Transfer type codes
`define UOC_TYPE_CTRL   2'h0
`define UOC_TYPE_SYNC   2'h1
`define UOC_TYPE_BULK   2'h2
`define UOC_TYPE_INTR   2'h3

// Reset values
`define UOC_RST_WORD    32'h0000_0000
`define UOC_RST_MPS     11'h000
`define UOC_RST_MPS0    2'h0
`define UOC_RST_EP0_ACT 1'b1

`endif

// >>> rtl/uoc_apb_slv.v
/*
 APB slave front end: decodes the eight register words, produces
 per-register write strobes and the read-data load moment.
 Assumes an APB master holding the request stable until pready.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uoc_defs.vh"

module uoc_apb_slv (
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	output wire        pready,
	output wire        pslverr,
	output wire        hit,
	output wire [2:0]  slot,
	output wire [7:0]  wr_en,
	output wire        rd_load
);

	// Word aligned and inside the register window
	function uoc_dec_hit;
		input [11:0] a;
		begin
			uoc_dec_hit = (a[1:0] == 2'h0) && (a <= `UOC_A_LAST);
		end
	endfunction

	// Zero wait states keeps software latency fixed at two cycles
	assign pready  = 1'b1;
	assign hit     = uoc_dec_hit(paddr);
	assign slot    = paddr[4:2];
	assign pslverr = psel & penable & ~uoc_dec_hit(paddr);
	// Read data is sampled in setup so prdata is a flop in access
	assign rd_load = psel & ~penable & ~pwrite;

	// One write strobe per register word, only in the access phase
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_wr
			assign wr_en[g] = psel & penable & pwrite & hit & (slot == g);
		end
	endgenerate

endmodule
`default_nettype wire

// >>> rtl/uoc_ep_ctl.v
/*
 Control word of one IN or OUT endpoint numbered 1 to 3: run and stop
 requests, NAK state, STALL, snoop, type, toggle, active, max size.
 Assumes the protocol engine pulses its event inputs for one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uoc_defs.vh"

module uoc_ep_ctl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        wr_en,
	input  wire [31:0] wdata,
	input  wire        usb_bus_reset,
	input  wire        setup_pkt,
	input  wire        xfer_done,
	input  wire        setup_done,
	input  wire        stop_ack,
	input  wire        toggle_adv,
	output wire [31:0] rdata,
	output reg         run_r,
	output reg         stop_r,
	output wire        stall_hs,
	output wire        nak_hs,
	output wire        zero_len,
	output reg         unchk_r,
	output reg  [1:0]  type_r,
	output reg         toggle_r,
	output reg         active_r,
	output reg  [10:0] mps_r,
	output reg         xfer_int_r,
	output reg         setup_int_r,
	output reg         dis_int_r
);

	reg  stall_r;
	reg  nak_r;
	wire stop_done;
	wire hw_done;

	function uoc_is_sync;
		input [1:0] t;
		begin
			uoc_is_sync = (t == `UOC_TYPE_SYNC);
		end
	endfunction

	assign stop_done = stop_r & stop_ack;
	assign hw_done   = xfer_done | setup_done | stop_done;

	// STALL outranks NAK except on sync, where STALL is ignored; sync IN sends zero length under NAK
	assign stall_hs = stall_r & ~uoc_is_sync(type_r);
	assign nak_hs   = nak_r & ~stall_hs;
	assign zero_len = nak_hs & uoc_is_sync(type_r);

	// Strobe bits are never stored, so they read back as zero
	assign rdata = {run_r, stop_r, 4'h0, 4'h0, stall_r, unchk_r, type_r,
		nak_r, toggle_r, active_r, 4'h0, mps_r};

	// Control state; hardware events win over software on one edge, except a forced toggle beats the advance
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r       <= 1'b0;
			stop_r      <= 1'b0;
			stall_r     <= 1'b0;
			unchk_r     <= 1'b0;
			type_r      <= `UOC_TYPE_CTRL;
			nak_r       <= 1'b0;
			toggle_r    <= 1'b0;
			active_r    <= 1'b0;
			mps_r       <= `UOC_RST_MPS;
			xfer_int_r  <= 1'b0;
			setup_int_r <= 1'b0;
			dis_int_r   <= 1'b0;
		end else begin
			// Cleared on the edge before the event pulse leaves
			if (hw_done)
				run_r <= 1'b0;
			else if (wr_en && wdata[`UOC_B_RUN])
				run_r <= 1'b1;
			// Only accepted while running; aborts an unfinished transfer
			if (stop_done)
				stop_r <= 1'b0;
			else if (wr_en && wdata[`UOC_B_STOP] && run_r)
				stop_r <= 1'b1;
			// Software alone changes STALL
			if (wr_en) begin
				stall_r <= wdata[`UOC_B_STALL];
				unchk_r <= wdata[`UOC_B_UNCHK];
				type_r  <= wdata[`UOC_B_TYPE_HI:`UOC_B_TYPE_LO];
				mps_r   <= wdata[`UOC_B_MPS_HI:0];
			end
			// Set wins over a clear strobe in the same write
			if (xfer_done || setup_pkt || (wr_en && wdata[`UOC_B_NAKSET]))
				nak_r <= 1'b1;
			else if (wr_en && wdata[`UOC_B_NAKCLR])
				nak_r <= 1'b0;
			// Forced value beats the engine's own advance
			if (wr_en && wdata[`UOC_B_FORCE1])
				toggle_r <= 1'b1;
			else if (wr_en && wdata[`UOC_B_FORCE0])
				toggle_r <= 1'b0;
			else if (toggle_adv)
				toggle_r <= ~toggle_r;
			if (usb_bus_reset)
				active_r <= 1'b0;
			else if (wr_en)
				active_r <= wdata[`UOC_B_ACTIVE];
			xfer_int_r  <= xfer_done;
			setup_int_r <= setup_done;
			dis_int_r   <= stop_done;
		end
	end

endmodule
`default_nettype wire

// >>> sim/uoc_assertions.sv
/*
 Checker for uoc_top: ties endpoint state outputs to engine events.
 Assumes a bind from the bench, one pclk domain and presetn low active.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uoc_defs.vh"

module uoc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        usb_bus_reset,
	input wire logic        out0_setup_token,
	input wire logic [3:0]  out_setup_pkt,
	input wire logic [3:0]  out_xfer_done,
	input wire logic [3:0]  out_setup_done,
	input wire logic [3:1]  out_stop_ack,
	input wire logic [3:0]  out_run,
	input wire logic [3:1]  out_stop_req,
	input wire logic [3:0]  out_stall_hs,
	input wire logic [3:0]  out_nak_hs,
	input wire logic [3:0]  out_setup_ack,
	input wire logic [3:0]  out_ep_active,
	input wire logic [3:1]  in_ep_active,
	input wire logic [3:0]  out_xfer_int,
	input wire logic [3:0]  out_setup_int,
	input wire logic [3:1]  out_dis_int,
	input wire logic [1:0]  out0_max_code,
	input wire logic [1:0]  in0_max_code,
	input wire logic [3:1]  in_zero_len,
	input wire logic [3:1]  in_hold,
	input wire logic [5:0]  in_transfer_type
);
	// A software STALL write in the same cycle beats the SETUP token clear
	wire logic ep0_stall_wr;
	assign ep0_stall_wr = psel && penable && pwrite && (paddr == `UOC_A_OUT0) && pwdata[21];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ep0_always_active: assert property (out_ep_active[0])
		else $error("ep0 active bit dropped");
	a_ep0_setup_done: assert property (out_setup_done[0] |=> !out_run[0] && out_setup_int[0])
		else $error("ep0 run not cleared before setup event");
	a_epn_done_clr: assert property (out_xfer_done[1] |=> !out_run[1] && out_xfer_int[1] && (out_nak_hs[1] || out_stall_hs[1]))
		else $error("ep1 completion did not clear run or set NAK");
	a_stop_ack_clr: assert property (out_stop_ack[1] && out_stop_req[1] |=> !out_stop_req[1] && !out_run[1] && out_dis_int[1])
		else $error("ep1 stop not finished before disabled event");
	a_stop_needs_run: assert property ($rose(out_stop_req[1]) |-> $past(out_run[1]))
		else $error("ep1 stop accepted while idle");
	a_setup_acked: assert property (out_setup_ack == out_setup_pkt)
		else $error("setup packet not acknowledged");
	a_stall_over_nak: assert property ((out_stall_hs & out_nak_hs) == 4'h0)
		else $error("NAK shown while stalled");
	a_ep0_stall_clr: assert property (out0_setup_token && !ep0_stall_wr |=> !out_stall_hs[0])
		else $error("ep0 stall kept after setup token");
	a_bus_reset_clr: assert property (usb_bus_reset |=> out_ep_active == 4'h1 && in_ep_active == 3'h0)
		else $error("active bits kept after bus reset");
	a_size_mirror: assert property (out0_max_code == in0_max_code)
		else $error("ep0 size code differs");
	a_pkt_sets_nak: assert property (out_setup_pkt[2] |=> out_nak_hs[2] || out_stall_hs[2])
		else $error("ep2 setup packet did not set NAK");
	a_sync_zero_len: assert property (in_zero_len[1] |-> in_transfer_type[1:0] == 2'h1 && !in_hold[1])
		else $error("zero length on non-sync endpoint");

	// Main scenarios reached
	c_ep0_setup: cover property (out_setup_done[0]);
	c_stop_done: cover property (out_dis_int[1]);
	c_bus_reset: cover property (usb_bus_reset);
endmodule
`default_nettype wire

// >>> sim/uoc_host_model.sv
/*
 Host side engine model: raises one-cycle event pulses toward uoc_top.
 Assumes calls come right after a rising pclk edge.
*/
`timescale 1ns/1ns
`default_nettype none

module uoc_host_model (
	input  wire logic        pclk,
	output var  logic [43:0] ev
);
	initial ev = 44'h000_0000_0000;

	// Group g, endpoint e, after gap idle cycles; SETUP packets go out whatever the NAK state
	task automatic pulse(input int g, input int e, input int gap);
		repeat (gap) @(posedge pclk);
		ev[4*g+e] <= 1'b1;
		@(posedge pclk);
		ev <= 44'h000_0000_0000;
	endtask
endmodule
`default_nettype wire

// >>> sim/uoc_top_bench.sv
/*
 Self-checking bench for uoc_top: APB master tasks and scenarios.
 Assumes uoc_host_model drives the engine events on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uoc_defs.vh"

module uoc_top_bench;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic        [11:0] paddr = 12'h000;
	logic        [31:0] pwdata = 32'h0000_0000;
	logic        [31:0] rd;
	logic              slv_err;
	wire  logic  [31:0] prdata;
	wire  logic        pready;
	wire  logic        pslverr;
	wire  logic  [3:0] out_stall_hs;
	wire  logic  [3:0] out_nak_hs;
	wire  logic  [3:1] in_zero_len;
	wire  logic  [3:1] in_hold;
	wire  logic  [3:1] in_stall_hs;
	wire  logic  [3:1] in_data_toggle;
	wire  logic  [32:0] out_max_bytes;
	wire  logic  [43:0] ev;
	int                errors = 0;
	int                num_checks = 0;

	always #10 pclk = ~pclk;

	uoc_host_model uoc_host_model_inst (.pclk(pclk), .ev(ev));

	uoc_top uoc_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_bus_reset(ev[40]), .out0_setup_token(ev[41]), .out_setup_pkt(ev[3:0]),
		.out_xfer_done(ev[7:4]), .out_setup_done(ev[11:8]), .out_stop_ack(ev[15:13]),
		.out_toggle_adv(ev[19:17]), .in_setup_pkt(ev[23:21]), .in_xfer_done(ev[27:25]),
		.in_setup_done(ev[31:29]), .in_stop_ack(ev[35:33]), .in_toggle_adv(ev[39:37]),
		.out_run(), .out_stop_req(), .out_stall_hs(out_stall_hs), .out_nak_hs(out_nak_hs),
		.out_setup_ack(), .out_unchecked(), .out_transfer_type(), .out_data_toggle(),
		.out_ep_active(), .out_max_bytes(out_max_bytes), .out0_max_code(), .out_xfer_int(), .out_setup_int(),
		.out_dis_int(), .in0_max_code(), .in_run(), .in_stop_req(), .in_stall_hs(in_stall_hs),
		.in_hold(in_hold), .in_zero_len(in_zero_len), .in_transfer_type(),
		.in_data_toggle(in_data_toggle), .in_ep_active(), .in_max_bytes(), .in_xfer_int(),
		.in_setup_int(), .in_dis_int()
	);

	// One APB transfer; the request stands until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge: the next setup must not reassign psel in this time step,
		// and results stored at the access edge are settled before any check
		@(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask

	task automatic t_reset;
		rdc("out0 reset", `UOC_A_OUT0, 32'h0000_8000);
		rdc("out2 reset", `UOC_A_OUT2, 32'h0000_0000);
		rdc("in3 reset", `UOC_A_IN3, 32'h0000_0000);
	endtask

	// Ep0: stop, type and active stay fixed, strobes read as zero
	task automatic t_ep0;
		apb(1'b1, `UOC_A_IN0MPS, 32'h0000_0003);
		apb(1'b1, `UOC_A_OUT0, 32'hC82C_0000);
		rdc("out0 word", `UOC_A_OUT0, 32'h8022_8003);
		chk("out0 stall wins", 32'h0000_0001, {31'h0000_0000, out_stall_hs[0] & ~out_nak_hs[0]});
		uoc_host_model_inst.pulse(10, 1, 0);
		rdc("out0 token", `UOC_A_OUT0, 32'h8002_8003);
		apb(1'b1, `UOC_A_OUT0, 32'h0400_0000);
		rdc("out0 nak clear", `UOC_A_OUT0, 32'h8000_8003);
		uoc_host_model_inst.pulse(0, 0, 2);
		rdc("out0 setup nak", `UOC_A_OUT0, 32'h8002_8003);
		uoc_host_model_inst.pulse(2, 0, 0);
		rdc("out0 setup done", `UOC_A_OUT0, 32'h0002_8003);
	endtask

	// Ep1 to ep3 OUT: toggle forcing, STALL kept, NAK, stop and completion
	task automatic t_epn;
		logic [11:0] a;
		int          e;
		for (a = `UOC_A_OUT1; a <= `UOC_A_OUT3; a = a + 12'h004) begin
			e = a[3:2];
			apb(1'b1, a, 32'hA838_87FF);
			rdc("outn set", a, 32'h803B_87FF);
			chk("outn stall", 32'h0000_0001, {31'h0000_0000, out_stall_hs[e] & ~out_nak_hs[e]});
			chk("outn max bytes", 32'h0000_07FF, {21'h00_0000, out_max_bytes[11*e-1 -: 11]});
			uoc_host_model_inst.pulse(0, e, 0);
			rdc("outn stall kept", a, 32'h803B_87FF);
			apb(1'b1, a, 32'h1408_87FF);
			rdc("outn clear", a, 32'h8008_87FF);
			uoc_host_model_inst.pulse(0, e, 1);
			rdc("outn setup nak", a, 32'h800A_87FF);
			apb(1'b1, a, 32'h4008_87FF);
			rdc("outn stop", a, 32'hC00A_87FF);
			uoc_host_model_inst.pulse(3, e, 0);
			rdc("outn stopped", a, 32'h000A_87FF);
			apb(1'b1, a, 32'h4008_87FF);
			rdc("outn stop idle", a, 32'h000A_87FF);
			apb(1'b1, a, 32'h8408_87FF);
			uoc_host_model_inst.pulse(1, e, 0);
			rdc("outn done", a, 32'h000A_87FF);
		end
		uoc_host_model_inst.pulse(10, 0, 0);
		rdc("out1 bus reset", `UOC_A_OUT1, 32'h000A_07FF);
		rdc("out0 bus reset", `UOC_A_OUT0, 32'h0002_8003);
	endtask

	// IN ep1: every type code against STALL and NAK, then toggle and parity
	task automatic t_in;
		logic [31:0] ty;
		for (int t = 0; t < 4; t++) begin
			ty = t << 18;
			apb(1'b1, `UOC_A_IN1, 32'h0820_8040 | ty);
			chk("in stall", {31'h0000_0000, t != 1}, {31'h0000_0000, in_stall_hs[1]});
			apb(1'b1, `UOC_A_IN1, 32'h0000_8040 | ty);
			chk("in zero len", {31'h0000_0000, t == 1}, {31'h0000_0000, in_zero_len[1]});
			chk("in hold", {31'h0000_0000, t != 1}, {31'h0000_0000, in_hold[1]});
		end
		apb(1'b1, `UOC_A_IN1, 32'h2004_8040);
		rdc("in odd frame", `UOC_A_IN1, 32'h0007_8040);
		apb(1'b1, `UOC_A_IN1, 32'h100C_8040);
		rdc("in data0", `UOC_A_IN1, 32'h000E_8040);
		uoc_host_model_inst.pulse(9, 1, 0);
		// The flip lands at the edge the pulse returns on; look one edge later
		@(posedge pclk);
		chk("in toggle adv", 32'h0000_0001, {31'h0000_0000, in_data_toggle[1]});
	endtask

	task automatic t_err;
		rdc("unmapped read", 12'h020, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0000_0000, slv_err});
		apb(1'b1, 12'h006, 32'hFFFF_FFFF);
		chk("unaligned err", 32'h0000_0001, {31'h0000_0000, slv_err});
		rdc("out2 untouched", `UOC_A_OUT2, 32'h000A_07FF);
		chk("mapped no err", 32'h0000_0000, {31'h0000_0000, slv_err});
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence after 12 cycles of reset
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_ep0;
		t_epn;
		t_in;
		t_err;
		end_sim;
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		end_sim;
	end
endmodule

bind uoc_top uoc_checker uoc_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .usb_bus_reset(usb_bus_reset),
	.out0_setup_token(out0_setup_token), .out_setup_pkt(out_setup_pkt),
	.out_xfer_done(out_xfer_done), .out_setup_done(out_setup_done), .out_stop_ack(out_stop_ack),
	.out_run(out_run), .out_stop_req(out_stop_req), .out_stall_hs(out_stall_hs),
	.out_nak_hs(out_nak_hs), .out_setup_ack(out_setup_ack), .out_ep_active(out_ep_active),
	.in_ep_active(in_ep_active), .out_xfer_int(out_xfer_int), .out_setup_int(out_setup_int),
	.out_dis_int(out_dis_int), .out0_max_code(out0_max_code), .in0_max_code(in0_max_code),
	.in_zero_len(in_zero_len), .in_hold(in_hold), .in_transfer_type(in_transfer_type)
);
`default_nettype wire
